// >>> shared/ccs_pkg.sv
// Constants, field layouts and state types of the charge cycle supervisor.
// Assumes one 40 MHz clock; all analog results arrive as synchronous levels.
package ccs_pkg;

  // ----------------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLOCK_MHZ         = 40;
  localparam int unsigned INT_PULSE_US      = 256;
  localparam int unsigned INT_PULSE_CYCLES  = INT_PULSE_US * CLOCK_MHZ;
  localparam int unsigned TICK_PERIOD_MS    = 1000;
  localparam int unsigned TICK_CYCLES_DEF   = TICK_PERIOD_MS * CLOCK_MHZ * 1000;
  localparam int unsigned TICKS_PER_HOUR    = 3600;
  localparam int unsigned TICKS_PER_QUARTER = 900;
  localparam int unsigned LOWBAT_HOURS      = 2;
  localparam int unsigned TICK_W            = 26;
  localparam int unsigned SAFETY_W          = 17;
  localparam int unsigned TOPOFF_W          = 12;
  localparam int unsigned PULSE_W           = 14;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [11:0] CTRL_OFFSET   = 12'h000;
  localparam logic [11:0] STATUS_OFFSET = 12'h004;
  localparam int unsigned REG_RESET_BIT = 10;

  // Control register, bit 0 at the right
  typedef struct packed {
    logic [1:0] safety_timer_duration;  // 5, 8, 10, 12 hours
    logic [1:0] topoff_setting;         // off, 15, 30, 45 minutes
    logic       cool_current_select;
    logic       warm_voltage_select;
    logic       half_rate_enable;
    logic       timer_enable;
    logic       term_enable;
    logic       charge_config_bit;
  } ccs_ctrl_type;

  localparam ccs_ctrl_type CTRL_RESET = 10'h20F;

  // Status register, bit 0 at the right
  typedef struct packed {
    logic       battery_switch;
    logic       supplement;
    logic       input_current_limit_flag;
    logic       input_voltage_limit_flag;
    logic       min_system_flag;
    logic       thermistor_fault;
    logic [2:0] input_source_status;
    logic [1:0] charge_fault_field;
    logic       topoff_running_flag;
    logic [1:0] charge_phase_field;
  } ccs_status_type;

  // ----------------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------------
  localparam logic [1:0] PHASE_DISABLED = 2'h0;
  localparam logic [1:0] PHASE_PRE      = 2'h1;
  localparam logic [1:0] PHASE_FAST     = 2'h2;
  localparam logic [1:0] PHASE_DONE     = 2'h3;
  localparam logic [1:0] FAULT_NONE     = 2'h0;
  localparam logic [1:0] FAULT_TIMER    = 2'h3;
  localparam logic [2:0] SOURCE_NONE    = 3'h0;
  localparam logic [2:0] SOURCE_BOOST   = 3'h7;

  typedef enum logic [2:0] {
    ZONE_COLD   = 3'h0,
    ZONE_COOL   = 3'h1,
    ZONE_NORMAL = 3'h2,
    ZONE_WARM   = 3'h3,
    ZONE_HOT    = 3'h4
  } ccs_zone_type;

  typedef enum logic [2:0] {
    ST_OFF    = 3'b001,
    ST_CHARGE = 3'b010,
    ST_DONE   = 3'b100
  } ccs_phase_type;

  // Whole state of the supervisor
  typedef struct packed {
    ccs_phase_type       phase;
    ccs_ctrl_type        ctrl;
    logic                enabled_q;
    logic [TICK_W-1:0]   tick_count;
    logic                tick;
    logic                half_phase;
    logic [SAFETY_W-1:0] safety_count;
    logic [TOPOFF_W-1:0] topoff_count;
    logic [1:0]          topoff_latched;
    logic                topoff_running;
    logic [1:0]          charge_fault;
    logic                therm_fault;
    logic                vlimit;
    logic                ilimit;
    logic                min_sys;
    logic                supplement;
    logic                battery_switch;
    logic                charge_active;
    logic                boost_enable;
    logic                warm_voltage_limit;
    logic                cool_current_reduce;
    logic                cool_current_fifth;
    logic                int_event;
    logic [31:0]         prdata;
    logic                pslverr;
  } ccs_state_type;

  typedef struct packed {
    logic               busy;
    logic [PULSE_W-1:0] count;
  } ccs_pulse_state_type;

endpackage : ccs_pkg

// >>> logic/ccs_int_pulse.sv
// Fixed-width interrupt pulse generator for the host interrupt line.
// Assumes the trigger is a one-cycle pulse in the pclk domain.
module ccs_int_pulse #(
  parameter int unsigned PULSE_CYCLES = ccs_pkg::INT_PULSE_CYCLES
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ce,
  input  wire logic trigger,
  output logic      host_int_n
);

  ccs_pkg::ccs_pulse_state_type st;
  ccs_pkg::ccs_pulse_state_type next_st;

  // ----------------------------------------------------------------------
  // Pulse timing
  // ----------------------------------------------------------------------
  // Triggers during a running pulse are dropped so each pulse stays whole
  always_comb begin
    next_st = st;
    if (ce) begin
      if (!st.busy) begin
        if (trigger) begin
          next_st.busy  = 1'b1;
          next_st.count = ccs_pkg::PULSE_W'(PULSE_CYCLES - 1);
        end
      end else if (st.count == '0) begin
        next_st.busy = 1'b0;
      end else begin
        next_st.count = st.count - 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign host_int_n = ~st.busy;  // Active low, straight from a flop

endmodule : ccs_int_pulse

// >>> logic/ccs_supervisor.sv
// Charge cycle supervisor: termination, top-off and safety timers,
// temperature gating, boost thermistor watch and status flags over APB.
// Assumes comparator and regulation inputs are synchronous to pclk.
//
// Overview of operation
// - Regulation active suppresses termination and halves the safety timer.
// - End cycle above recharge and below termination current; open switch.
// - Termination sets phase field to 11 and pulses the interrupt.
// - Optional top-off timer follows safety pause and half rate; flag shown.
// - Top-off resets on enable edge, termination rise, or register reset.
// - Top-off setting captured at termination; later writes wait for recharge.
// - Interrupt pulse at top-off start and at top-off expiry.
// - Start charging only inside cold-to-hot zone; suspend outside it.
// - Warm zone selects programmed voltage or 4.1V by warm select.
// - Cool zone reduces current, optionally to 20 percent.
// - No termination in cool or warm zone.
// - Boost leaving temp window suspends, source 000, thermistor fault.
// - Safety limit 2 hours below low battery, else programmed hours.
// - Safety expiry sets charge fault 11 and pulses interrupt.
// - Host programs safety duration and may disable the safety timer.
// - Regulation or cool zone halves safety rate unless half enable is 0.
// - Safety timer freezes during faults and resumes afterwards.
// - Charge enable toggle resets the safety timer.
// - Minimum system flag while system rail held at minimum.
// - Input voltage and current limit flags follow their loops.
// - Supplement mode turns switch on at 180 or 45 mV drop.
// - Interrupt event gives one 256 microsecond pulse; events during a pulse are dropped.
// - Phase field 00 off, 01 pre, 10 fast, 11 done.
module ccs_supervisor #(
  parameter int unsigned TICK_CYCLES      = ccs_pkg::TICK_CYCLES_DEF,
  parameter int unsigned INT_PULSE_CYCLES = ccs_pkg::INT_PULSE_CYCLES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Analog and pin levels
  input  wire logic        charge_enable_n,
  input  wire logic [2:0]  thermistor_sense_input,
  input  wire logic        vbat_above_recharge,
  input  wire logic        ichg_below_term,
  input  wire logic        vbat_below_precharge,
  input  wire logic        low_battery_threshold,
  input  wire logic        vbat_above_min_system,
  input  wire logic        vsys_drop_180mv,
  input  wire logic        vsys_drop_45mv,
  input  wire logic        sys_at_min_regulation,
  input  wire logic        input_vlimit_active,
  input  wire logic        input_ilimit_active,
  input  wire logic        thermal_reg_active,
  input  wire logic        fault_present,
  input  wire logic        boost_request,
  input  wire logic        boost_temp_ok,
  input  wire logic [2:0]  input_source_code,
  // Control outputs
  output logic             battery_switch,
  output logic             charge_active,
  output logic             boost_enable,
  output logic             warm_voltage_limit,
  output logic             cool_current_reduce,
  output logic             cool_current_fifth,
  output logic [2:0]       input_source_status,
  output logic             host_int_n
);

  ccs_pkg::ccs_state_type  st;
  ccs_pkg::ccs_state_type  next_st;
  ccs_pkg::ccs_status_type status;
  ccs_pkg::ccs_zone_type   zone;

  logic                         temp_ok;
  logic                         in_cool;
  logic                         in_warm;
  logic                         regulating;
  logic                         half_rate;
  logic                         charge_en;
  logic                         restart;
  logic                         paused;
  logic                         term_ok;
  logic                         term_hit;
  logic                         advance;
  logic                         setup;
  logic                         wr;
  logic [ccs_pkg::SAFETY_W-1:0] safety_limit;
  logic [ccs_pkg::TOPOFF_W-1:0] topoff_limit;
  logic [ccs_pkg::SAFETY_W-1:0] safety_hours;

  // ----------------------------------------------------------------------
  // Condition decode
  // ----------------------------------------------------------------------
  assign zone       = ccs_pkg::ccs_zone_type'(thermistor_sense_input);
  assign temp_ok    = (zone == ccs_pkg::ZONE_COOL) ||
                      (zone == ccs_pkg::ZONE_NORMAL) ||
                      (zone == ccs_pkg::ZONE_WARM);
  assign in_cool    = (zone == ccs_pkg::ZONE_COOL);
  assign in_warm    = (zone == ccs_pkg::ZONE_WARM);
  assign regulating = input_vlimit_active | input_ilimit_active |
                      thermal_reg_active;
  assign half_rate  = st.ctrl.half_rate_enable & (regulating | in_cool);
  assign charge_en  = st.ctrl.charge_config_bit & ~charge_enable_n;
  assign restart    = charge_en & ~st.enabled_q;
  // any fault or temperature suspend freezes the timers
  assign paused     = fault_present | ~temp_ok;
  assign term_ok    = st.ctrl.term_enable & ~regulating & ~in_cool & ~in_warm;
  assign term_hit   = vbat_above_recharge & ichg_below_term & term_ok;
  // half rate takes every second unpaused tick
  assign advance    = st.tick & ~paused & (~half_rate | st.half_phase);

  // Safety limit in ticks, low battery overriding the programmed hours
  always_comb begin
    case (st.ctrl.safety_timer_duration)
      2'h0:    safety_hours = ccs_pkg::SAFETY_W'(5);
      2'h1:    safety_hours = ccs_pkg::SAFETY_W'(8);
      2'h2:    safety_hours = ccs_pkg::SAFETY_W'(10);
      default: safety_hours = ccs_pkg::SAFETY_W'(12);
    endcase
  end

  assign safety_limit = low_battery_threshold ?
      ccs_pkg::SAFETY_W'(ccs_pkg::LOWBAT_HOURS * ccs_pkg::TICKS_PER_HOUR) :
      ccs_pkg::SAFETY_W'(safety_hours * ccs_pkg::SAFETY_W'(
        ccs_pkg::TICKS_PER_HOUR));

  // duration comes from the copy latched at termination
  assign topoff_limit = ccs_pkg::TOPOFF_W'(st.topoff_latched *
      ccs_pkg::TOPOFF_W'(ccs_pkg::TICKS_PER_QUARTER));

  // ----------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------
  assign setup = psel & ~penable;
  assign wr    = psel & penable & pwrite & ce;

  // Status word, assembled from live state
  always_comb begin
    status = '0;
    case (st.phase)
      ccs_pkg::ST_CHARGE: status.charge_phase_field = vbat_below_precharge ?
                              ccs_pkg::PHASE_PRE : ccs_pkg::PHASE_FAST;
      ccs_pkg::ST_DONE:   status.charge_phase_field = ccs_pkg::PHASE_DONE;
      default:            status.charge_phase_field = ccs_pkg::PHASE_DISABLED;
    endcase
    status.topoff_running_flag      = st.topoff_running;
    status.charge_fault_field       = st.charge_fault;
    status.input_source_status      = input_source_status;
    status.thermistor_fault         = st.therm_fault;
    status.min_system_flag          = st.min_sys;
    status.input_voltage_limit_flag = st.vlimit;
    status.input_current_limit_flag = st.ilimit;
    status.supplement               = st.supplement;
    status.battery_switch           = st.battery_switch;
  end

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  always_comb begin
    next_st = st;
    if (ce) begin
      next_st.enabled_q = charge_en;
      next_st.int_event = 1'b0;

      next_st.tick = 1'b0;
      if (st.tick_count == ccs_pkg::TICK_W'(TICK_CYCLES - 1)) begin
        next_st.tick_count = '0;
        next_st.tick       = 1'b1;
      end else begin
        next_st.tick_count = st.tick_count + 1'b1;
      end
      if (st.tick && !paused) begin
        next_st.half_phase = ~st.half_phase;
      end

      next_st.min_sys = sys_at_min_regulation;
      next_st.vlimit  = input_vlimit_active;
      next_st.ilimit  = input_ilimit_active;

      // Read data is caught in the setup cycle, so access needs no wait
      if (setup) begin
        next_st.pslverr = 1'b0;
        if (paddr == ccs_pkg::CTRL_OFFSET) begin
          next_st.prdata = {22'h00_0000, st.ctrl};
        end else if (paddr == ccs_pkg::STATUS_OFFSET) begin
          next_st.prdata = {18'h0_0000, status};
        end else begin
          next_st.prdata  = 32'h0000_0000;
          next_st.pslverr = 1'b1;
        end
      end

      // enable edge restarts the safety timer and clears its fault
      if (restart) begin
        next_st.safety_count = '0;
        next_st.charge_fault = ccs_pkg::FAULT_NONE;
        next_st.topoff_count   = '0;
        next_st.topoff_running = 1'b0;
      end

      // Register write first: a termination in the same cycle wins over reset
      if (wr && paddr == ccs_pkg::CTRL_OFFSET) begin
        if (pwdata[ccs_pkg::REG_RESET_BIT]) begin
          next_st.ctrl           = ccs_pkg::CTRL_RESET;
          next_st.topoff_count   = '0;
          next_st.topoff_running = 1'b0;
        end else begin
          next_st.ctrl = pwdata[9:0];
        end
      end

      case (st.phase)
        ccs_pkg::ST_OFF: begin
          if (charge_en && temp_ok && !fault_present &&
              st.charge_fault != ccs_pkg::FAULT_TIMER) begin
            next_st.phase = ccs_pkg::ST_CHARGE;
          end
        end
        ccs_pkg::ST_CHARGE: begin
          if (!charge_en) begin
            next_st.phase = ccs_pkg::ST_OFF;
          end else if (st.ctrl.timer_enable &&
                       st.safety_count >= safety_limit) begin
            next_st.phase        = ccs_pkg::ST_OFF;
            next_st.charge_fault = ccs_pkg::FAULT_TIMER;
            next_st.int_event    = 1'b1;
          end else if (term_hit && !paused) begin
            next_st.phase          = ccs_pkg::ST_DONE;
            next_st.int_event      = 1'b1;
            next_st.topoff_latched = st.ctrl.topoff_setting;
            next_st.topoff_count   = '0;
            next_st.topoff_running = (st.ctrl.topoff_setting != 2'h0);
          end else if (st.ctrl.timer_enable && advance) begin
            // counting gated by enable, rate and pause
            next_st.safety_count = st.safety_count + 1'b1;
          end
        end
        ccs_pkg::ST_DONE: begin
          if (!charge_en) begin
            next_st.phase          = ccs_pkg::ST_OFF;
            next_st.topoff_running = 1'b0;
          end else if (!vbat_above_recharge) begin
            // Recharge: new cycle, timers start over
            next_st.phase          = ccs_pkg::ST_CHARGE;
            next_st.topoff_running = 1'b0;
            next_st.safety_count   = '0;
          end else if (st.topoff_running && advance) begin
            // top-off follows the safety timer's pause and rate
            if (st.topoff_count + 1'b1 >= topoff_limit) begin
              next_st.topoff_running = 1'b0;
              next_st.int_event      = 1'b1;
            end else begin
              next_st.topoff_count = st.topoff_count + 1'b1;
            end
          end
        end
        default: next_st.phase = ccs_pkg::ST_OFF;
      endcase

      // boost thermistor watch, fault entry raises an interrupt
      next_st.therm_fault = boost_request & ~boost_temp_ok;
      if (next_st.therm_fault && !st.therm_fault) begin
        next_st.int_event = 1'b1;
      end
      next_st.boost_enable = boost_request & boost_temp_ok;

      next_st.warm_voltage_limit  = in_warm & st.ctrl.warm_voltage_select;
      next_st.cool_current_reduce = in_cool;
      next_st.cool_current_fifth  = in_cool & st.ctrl.cool_current_select;

      // supplement threshold depends on battery against min system
      next_st.supplement = vbat_above_min_system ? vsys_drop_180mv :
                                                   vsys_drop_45mv;
      next_st.charge_active = (st.phase == ccs_pkg::ST_CHARGE) & ~paused &
                              charge_en;
      // switch opens once done and top-off is over
      next_st.battery_switch = next_st.charge_active |
                               ((st.phase == ccs_pkg::ST_DONE) &
                                st.topoff_running) |
                               next_st.supplement;
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st      <= '0;
      st.phase <= ccs_pkg::ST_OFF;
      st.ctrl  <= ccs_pkg::CTRL_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign pready              = psel & penable & ce;
  assign prdata              = st.prdata;
  assign pslverr             = st.pslverr & pready;
  assign battery_switch      = st.battery_switch;
  assign charge_active       = st.charge_active;
  assign boost_enable        = st.boost_enable;
  assign warm_voltage_limit  = st.warm_voltage_limit;
  assign cool_current_reduce = st.cool_current_reduce;
  assign cool_current_fifth  = st.cool_current_fifth;
  // boost source code, forced to none on thermistor fault
  assign input_source_status = st.therm_fault  ? ccs_pkg::SOURCE_NONE :
                               st.boost_enable ? ccs_pkg::SOURCE_BOOST :
                                                 input_source_code;

  ccs_int_pulse #(
    .PULSE_CYCLES (INT_PULSE_CYCLES)
  ) u_int_pulse (
    .pclk       (pclk),
    .presetn    (presetn),
    .ce         (ce),
    .trigger    (st.int_event),
    .host_int_n (host_int_n)
  );

endmodule : ccs_supervisor

// >>> verification/ccs_host_model.sv
// APB host model: single transfers on request of the bench.
// Assumes one clock, no wait-state limit other than the bench timeout.
module ccs_host_model (
  input  wire logic        pclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [11:0] paddr,
  output logic      [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {psel, penable, pwrite, paddr, pwdata} = '0;
  // Setup, then access held until pready is sampled high
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic err);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'h1, 1'h0, w, a, d};
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    q = prdata;
    err = pslverr;
    // Released data lines carry junk, not the old word
    {psel, penable, pwdata} <= {1'h0, 1'h0, ~d};
  endtask : xfer
endmodule : ccs_host_model

// >>> verification/ccs_supervisor_properties.sv
// Port-level checker for the charge cycle supervisor, bound to its top.
// Assumes one pclk domain and asynchronous active-low presetn.
module ccs_checker #(
  parameter int unsigned INT_PULSE_CYCLES = 8
) (
  input wire logic       pclk, presetn, ce, charge_enable_n,
  input wire logic [2:0] thermistor_sense_input, input_source_status,
  input wire logic       vbat_above_min_system, vsys_drop_180mv,
  input wire logic       boost_temp_ok, battery_switch, charge_active,
  input wire logic       boost_enable, cool_current_reduce,
  input wire logic       warm_voltage_limit, host_int_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [15:0] low_cnt;
  // Low-time counter; frozen cycles do not count toward the pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) low_cnt <= '0;
    else if (host_int_n) low_cnt <= '0;
    else if (ce) low_cnt <= low_cnt + 16'h0001;
  end
  property p_pulse_len; $rose(host_int_n) |-> low_cnt == INT_PULSE_CYCLES;
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("int width");
  property p_boost_cut; ce && !boost_temp_ok |=> !boost_enable; endproperty
  a_boost_cut: assert property (p_boost_cut) else $error("boost on");
  property p_src_zero; ce && boost_enable && !boost_temp_ok
    |=> input_source_status == 3'h0; endproperty
  a_src_zero: assert property (p_src_zero) else $error("source code");
  property p_temp_gate; ce && (thermistor_sense_input == 3'h0 ||
    thermistor_sense_input >= 3'h4) |=> !charge_active; endproperty
  a_temp_gate: assert property (p_temp_gate) else $error("charging");
  property p_cool; ce && thermistor_sense_input != 3'h1
    |=> !cool_current_reduce; endproperty
  a_cool: assert property (p_cool) else $error("cool cut");
  property p_warm; ce && thermistor_sense_input != 3'h3
    |=> !warm_voltage_limit; endproperty
  a_warm: assert property (p_warm) else $error("warm limit");
  property p_suppl; ce && vbat_above_min_system && vsys_drop_180mv
    |=> battery_switch; endproperty
  a_suppl: assert property (p_suppl) else $error("switch off");
  property p_disable; ce && charge_enable_n |=> !charge_active; endproperty
  a_disable: assert property (p_disable) else $error("still on");
endmodule : ccs_checker
bind ccs_supervisor ccs_checker #(.INT_PULSE_CYCLES(INT_PULSE_CYCLES))
  ccs_checker_i (.pclk, .presetn, .ce, .charge_enable_n,
  .thermistor_sense_input, .input_source_status, .vbat_above_min_system,
  .vsys_drop_180mv, .boost_temp_ok, .battery_switch, .charge_active,
  .boost_enable, .cool_current_reduce, .warm_voltage_limit, .host_int_n);

// >>> verification/tb_top.sv
// Self-checking bench for the charge cycle supervisor.
// Assumes the host model and the bound checker are compiled first.
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin fail_count++; \
  $display("wrong value %s exp %0h got %0h", n, e, s); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TICK = 4;
  localparam int LIM = ccs_pkg::LOWBAT_HOURS * ccs_pkg::TICKS_PER_HOUR * TICK;
  logic pclk = 0, presetn = 0, ce = 1, charge_enable_n = 1;
  logic [2:0] thermistor_sense_input = 3'h2, input_source_code = 3'h2;
  logic vbat_above_recharge = 0, ichg_below_term = 0, vbat_below_precharge = 0;
  logic low_battery_threshold = 0, vbat_above_min_system = 0;
  logic vsys_drop_180mv = 0, vsys_drop_45mv = 0, sys_at_min_regulation = 0;
  logic input_vlimit_active = 0, input_ilimit_active = 0, fault_present = 0;
  logic thermal_reg_active = 0, boost_request = 0, boost_temp_ok = 1;
  logic psel, penable, pwrite, pready, pslverr, e, host_int_n;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic battery_switch, charge_active, boost_enable, warm_voltage_limit;
  logic cool_current_reduce, cool_current_fifth;
  logic [2:0] input_source_status;
  int fail_count = 0, n_tests = 0, cycles = 0, n;
  always #12.5 pclk = ~pclk;
  ccs_supervisor #(.TICK_CYCLES(TICK), .INT_PULSE_CYCLES(8)) ccs_supervisor_i (
    .pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .charge_enable_n, .thermistor_sense_input,
    .vbat_above_recharge, .ichg_below_term, .vbat_below_precharge,
    .low_battery_threshold, .vbat_above_min_system, .vsys_drop_180mv,
    .vsys_drop_45mv, .sys_at_min_regulation, .input_vlimit_active,
    .input_ilimit_active, .thermal_reg_active, .fault_present, .boost_request,
    .boost_temp_ok, .input_source_code, .battery_switch, .charge_active,
    .boost_enable, .warm_voltage_limit, .cool_current_reduce,
    .cool_current_fifth, .input_source_status, .host_int_n);
  ccs_host_model ccs_host_model_i (.pclk, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr);
  // Hang guard, well above the longest timer run
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 60000) begin
      fail_count++;
      end_of_test();
    end
  end
  task automatic cyc(input int k);
    repeat (k) @(posedge pclk);
  endtask : cyc
  task automatic rd(input logic [11:0] a);
    ccs_host_model_i.xfer(1'h0, a, 32'h0000_0000, q, e);
  endtask : rd
  task automatic wait_int(input int lim);
    n = 0;
    while (host_int_n !== 1'h0 && n < lim) begin
      @(posedge pclk);
      n++;
    end
  endtask : wait_int
  task automatic t_regs;
    rd(12'h000);
    `CHK("ctrl reset", 32'h0000_020F, q)
    ccs_host_model_i.xfer(1'h1, 12'h000, 32'h0000_030F, q, e);
    rd(12'h000);
    `CHK("ctrl", 32'h0000_030F, q)
    ccs_host_model_i.xfer(1'h1, 12'h000, 32'h0000_020F, q, e);
    rd(12'h00C);
    `CHK("unmapped", 33'h0_0000_0001, {q, e})
  endtask : t_regs
  task automatic t_zone;
    {thermistor_sense_input, charge_enable_n} <= 4'h0;
    cyc(4);
    `CHK("cold", 1'h0, charge_active)
    thermistor_sense_input <= 3'h1;
    cyc(4);
    `CHK("cool", 2'h2, {cool_current_reduce, cool_current_fifth})
    thermistor_sense_input <= 3'h2;
    cyc(4);
    rd(12'h004);
    `CHK("phase", 3'h6, {charge_active, q[1:0]})
  endtask : t_zone
  task automatic t_term;
    ccs_host_model_i.xfer(1'h1, 12'h000, 32'h0000_020D, q, e);
    {vbat_above_recharge, ichg_below_term} <= 2'h3;
    rd(12'h004);
    `CHK("no term", 2'h2, q[1:0])
    ccs_host_model_i.xfer(1'h1, 12'h000, 32'h0000_020F, q, e);
    wait_int(20);
    `CHK("int delay", 1'h1, n <= 4)
    rd(12'h004);
    `CHK("done", 3'h3, {battery_switch, q[1:0]})
  endtask : t_term
  task automatic t_safety;
    charge_enable_n <= 1'h1;
    cyc(2);
    charge_enable_n <= 1'h0;
    {vbat_above_recharge, ichg_below_term, low_battery_threshold} <= 3'h1;
    cyc(20);
    wait_int(40000);
    `CHK("expiry time", 1'h1, n > LIM - 40 && n < LIM + 10)
    rd(12'h004);
    `CHK("timer fault", 3'h3, {charge_active, q[4:3]})
  endtask : t_safety
  task automatic t_boost;
    {charge_enable_n, boost_request} <= 2'h3;
    cyc(4);
    `CHK("boost", 4'hF, {boost_enable, input_source_status})
    {ce, boost_temp_ok} <= 2'h0;
    cyc(3);
    `CHK("frozen", 1'h1, boost_enable)
    ce <= 1'h1;
    cyc(3);
    `CHK("boost cut", 4'h0, {boost_enable, input_source_status})
    rd(12'h004);
    `CHK("therm fault", 1'h1, q[8])
    boost_temp_ok <= 1'h1;
    cyc(4);
    `CHK("resume", 4'hF, {boost_enable, input_source_status})
  endtask : t_boost
  task automatic t_flags;
    {sys_at_min_regulation, input_vlimit_active, input_ilimit_active} <= 3'h7;
    {vbat_above_min_system, vsys_drop_180mv, boost_request} <= 3'h6;
    cyc(3);
    rd(12'h004);
    `CHK("min system", 1'h1, q[9])
    `CHK("limits", 2'h3, q[11:10])
    `CHK("supplement", 2'h3, q[13:12])
  endtask : t_flags
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_of_test
  // Main sequence: reset, then one task per scenario
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'h1;
    cyc(2);
    t_regs();
    t_zone();
    t_term();
    t_safety();
    t_boost();
    t_flags();
    end_of_test();
  end
endmodule : tb_top
